// File: rtl/acpc_core.sv
// Post-conversion compute unit: accumulator, averaging, low-pass filter and threshold test
`timescale 1ns/1ns
`default_nettype none

module acpc_core (
  // Clock and reset
  input  wire  logic                        clk,
  input  wire  logic                        rst_n,
  // Register port
  input  wire  logic [acpc_pkg::ADDR_W-1:0] reg_addr,
  input  wire  logic [31:0]                 reg_wdata,
  input  wire  logic                        reg_wr,
  input  wire  logic                        reg_rd,
  output logic       [31:0]                 reg_rdata,
  // Conversion core
  input  wire  logic                        conv_trigger,
  input  wire  logic                        conv_valid,
  input  wire  logic [acpc_pkg::RES_W-1:0]  conv_result,
  output logic                              retrigger,
  // Status
  output logic                              conv_done_flag,
  output logic                              threshold_irq_flag,
  output logic                              acc_clear_busy
);

  acpc_pkg::acpc_state_t s_q;
  acpc_pkg::acpc_state_t s_d;

  // Signed threshold decision
  function automatic logic thr_hit(input logic [2:0] tm,
                                   input logic signed [acpc_pkg::ERR_W-1:0] err,
                                   input logic signed [acpc_pkg::ERR_W-1:0] up,
                                   input logic signed [acpc_pkg::ERR_W-1:0] lo);
    logic r;
    r = 1'b0;
    unique case (acpc_pkg::acpc_thr_t'(tm))
      acpc_pkg::THR_NEVER:   r = 1'b0;
      acpc_pkg::THR_LT_LOW:  r = err < lo;
      acpc_pkg::THR_GE_LOW:  r = err >= lo;
      acpc_pkg::THR_INSIDE:  r = (err >= lo) && (err <= up);
      acpc_pkg::THR_OUTSIDE: r = (err < lo) || (err > up);
      acpc_pkg::THR_LE_UP:   r = err <= up;
      acpc_pkg::THR_GT_UP:   r = err > up;
      acpc_pkg::THR_ALWAYS:  r = 1'b1;
    endcase
    return r;
  endfunction : thr_hit

  // Mode counts samples
  function automatic logic counts(input logic [2:0] md);
    return md != acpc_pkg::MODE_BASIC;
  endfunction : counts

  logic                                  cycle_end;
  logic                                  clear_now;
  logic                                  auto_clear;
  logic signed [acpc_pkg::ERR_W-1:0]     sample_term;
  logic signed [acpc_pkg::ERR_W-1:0]     acc_base;
  logic signed [acpc_pkg::ERR_W-1:0]     acc_sum;
  logic [acpc_pkg::ACC_W-1:0]            acc_src;
  logic [acpc_pkg::CNT_W-1:0]            cnt_src;
  logic [acpc_pkg::CNT_W-1:0]            cnt_new;
  logic [acpc_pkg::ACC_W-1:0]            acc_new;
  logic                                  test_en;
  logic                                  hit;
  logic signed [acpc_pkg::ERR_W-1:0]     err_val;
  logic signed [acpc_pkg::ERR_W-1:0]     up_ext;
  logic signed [acpc_pkg::ERR_W-1:0]     lo_ext;
  logic [31:0]                           rd_mux;

  always_comb begin
    s_d = s_q;
    s_d.retrigger = 1'b0;
    // One cycle ends on each conversion, or on every second one with double sampling
    cycle_end = conv_valid && (!s_q.cfg.double_sample_en || s_q.second_phase);
    // Sample term: current result, or second minus first
    if (s_q.cfg.double_sample_en) begin
      sample_term = acpc_pkg::ERR_W'($signed({1'b0, conv_result}))
                  - acpc_pkg::ERR_W'($signed({1'b0, s_q.current_result}));
    end else begin
      sample_term = acpc_pkg::ERR_W'($signed({1'b0, conv_result}));
    end
    // Automatic clear at a trigger: always in burst mode, in average mode once the count reaches the repeat setting
    auto_clear = 1'b0;
    if (conv_trigger) begin
      unique case (acpc_pkg::acpc_mode_t'(s_q.cfg.compute_mode_sel))
        acpc_pkg::MODE_AVG:   auto_clear = s_q.sample_counter >= s_q.cfg.repeat_setting;
        acpc_pkg::MODE_BURST: auto_clear = 1'b1;
        default:              auto_clear = 1'b0;
      endcase
    end
    acc_src = auto_clear ? '0 : s_q.accumulator;
    cnt_src = auto_clear ? '0 : s_q.sample_counter;
    // Accumulation, plain or low-pass; signed sample may add or subtract
    acc_base = acpc_pkg::ERR_W'($signed({2'b00, acc_src}));
    if (s_q.cfg.compute_mode_sel == acpc_pkg::MODE_LPF) begin
      acc_sum = sample_term + acc_base
              - acpc_pkg::ERR_W'($signed({2'b00, acc_src >> s_q.cfg.shift_count}));
    end else begin
      acc_sum = sample_term + acc_base;
    end
    acc_new = acc_sum[acpc_pkg::ACC_W-1:0];
    cnt_new = (cnt_src == acpc_pkg::CNT_MAX) ? cnt_src
            : cnt_src + acpc_pkg::CNT_W'(1);
    // Error value: sample in basic mode, filtered value otherwise
    if (s_q.cfg.compute_mode_sel == acpc_pkg::MODE_BASIC) begin
      err_val = sample_term;
    end else begin
      err_val = acpc_pkg::ERR_W'($signed({2'b00, acc_new >> s_q.cfg.shift_count}));
    end
    up_ext = acpc_pkg::ERR_W'($signed(s_q.cfg.upper_limit));
    lo_ext = acpc_pkg::ERR_W'($signed(s_q.cfg.lower_limit));
    unique case (acpc_pkg::acpc_mode_t'(s_q.cfg.compute_mode_sel))
      acpc_pkg::MODE_BASIC: test_en = 1'b1;
      acpc_pkg::MODE_ACCUM: test_en = 1'b1;
      default:              test_en = cnt_new >= s_q.cfg.repeat_setting;
    endcase
    hit = thr_hit(s_q.cfg.thr_mode, err_val, up_ext, lo_ext);
    clear_now = 1'b0;

    // Read data stands in the cycle after the read strobe
    unique case (reg_addr)
      acpc_pkg::OFS_CTRL:   rd_mux = 32'(
          {s_q.cfg.thr_mode, 2'b00, s_q.cfg.justify_left, (s_q.fsm == acpc_pkg::ST_CLEAR),
           1'b0, s_q.cfg.shift_count, s_q.cfg.double_sample_en, s_q.cfg.compute_mode_sel});
      acpc_pkg::OFS_REPEAT: rd_mux = 32'(s_q.cfg.repeat_setting);
      acpc_pkg::OFS_STATUS: rd_mux = 32'(
          {(s_q.fsm == acpc_pkg::ST_CLEAR), s_q.lower_flag, s_q.upper_flag,
           s_q.acc_overflow_flag, s_q.threshold_irq_flag, s_q.conv_done_flag});
      acpc_pkg::OFS_ACC:    rd_mux = 32'(s_q.accumulator);
      acpc_pkg::OFS_FILTER: rd_mux = 32'(s_q.filter_output);
      acpc_pkg::OFS_COUNT:  rd_mux = 32'(s_q.sample_counter);
      acpc_pkg::OFS_UPPER:  rd_mux = 32'(s_q.cfg.upper_limit);
      acpc_pkg::OFS_LOWER:  rd_mux = 32'(s_q.cfg.lower_limit);
      acpc_pkg::OFS_RESULT: rd_mux = 32'(s_q.current_result);
      acpc_pkg::OFS_PREV:   rd_mux = 32'(s_q.previous_result);
      default:              rd_mux = 32'h0000_0000;
    endcase
    s_d.rdata = reg_rd ? rd_mux : 32'h0000_0000;

    // Register writes; status bits other than overflow and busy are write-one-to-clear
    if (reg_wr) begin
      unique case (reg_addr)
        acpc_pkg::OFS_CTRL: begin
          s_d.cfg.compute_mode_sel = reg_wdata[acpc_pkg::CTRL_MODE_LSB +: 3];
          s_d.cfg.double_sample_en = reg_wdata[acpc_pkg::CTRL_DOUBLE_SAMPLE_EN_BIT];
          s_d.cfg.shift_count      = reg_wdata[acpc_pkg::CTRL_SHIFT_LSB +: 3];
          s_d.cfg.justify_left     = reg_wdata[acpc_pkg::CTRL_JUST_BIT];
          s_d.cfg.thr_mode         = reg_wdata[acpc_pkg::CTRL_THR_LSB +: 3];
          clear_now                = reg_wdata[acpc_pkg::CTRL_CLEAR_BIT];
        end
        acpc_pkg::OFS_REPEAT: s_d.cfg.repeat_setting = reg_wdata[acpc_pkg::CNT_W-1:0];
        acpc_pkg::OFS_STATUS: begin
          if (reg_wdata[acpc_pkg::ST_DONE_BIT]) s_d.conv_done_flag = 1'b0;
          if (reg_wdata[acpc_pkg::ST_THR_BIT]) s_d.threshold_irq_flag = 1'b0;
          if (reg_wdata[acpc_pkg::ST_UPPER_BIT]) s_d.upper_flag = 1'b0;
          if (reg_wdata[acpc_pkg::ST_LOWER_BIT]) s_d.lower_flag = 1'b0;
        end
        acpc_pkg::OFS_UPPER: s_d.cfg.upper_limit = reg_wdata[acpc_pkg::LIM_W-1:0];
        acpc_pkg::OFS_LOWER: s_d.cfg.lower_limit = reg_wdata[acpc_pkg::LIM_W-1:0];
        default: ;
      endcase
    end

    // Capture of results and phase of double sampling
    if (conv_valid) begin
      s_d.current_result = conv_result;
      s_d.previous_result = s_q.current_result;
      s_d.second_phase = s_q.cfg.double_sample_en && !s_q.second_phase;
      s_d.conv_done_flag = 1'b1;
    end

    unique case (s_q.fsm)
      acpc_pkg::ST_RUN: begin
        if (clear_now) begin
          s_d.fsm = acpc_pkg::ST_CLEAR;
          s_d.clr_cnt = acpc_pkg::CLEAR_CYCLES;
          s_d.accumulator = '0;
          s_d.sample_counter = '0;
          s_d.acc_overflow_flag = 1'b0;
        end else begin
          if (auto_clear && !cycle_end) begin
            s_d.accumulator = '0;
            s_d.sample_counter = '0;
          end
          if (cycle_end) begin
            if (counts(s_q.cfg.compute_mode_sel)) begin
              s_d.accumulator = acc_new;
              s_d.sample_counter = cnt_new;
              s_d.filter_output = acc_new >> s_q.cfg.shift_count;
              if (acc_sum[acpc_pkg::ERR_W-1:acpc_pkg::ACC_W] != '0) begin
                s_d.acc_overflow_flag = 1'b1;
              end
            end
            if (test_en) begin
              s_d.upper_flag = err_val > up_ext;
              s_d.lower_flag = err_val < lo_ext;
              if (hit || (s_d.acc_overflow_flag && counts(s_q.cfg.compute_mode_sel))) begin
                s_d.threshold_irq_flag = 1'b1;
              end
            end
            if (s_q.cfg.compute_mode_sel == acpc_pkg::MODE_BURST
                && cnt_new < s_q.cfg.repeat_setting) begin
              s_d.retrigger = 1'b1;
            end
          end
        end
      end
      acpc_pkg::ST_CLEAR: begin
        // Results arriving while clearing are ignored by the accumulator
        s_d.accumulator = '0;
        s_d.sample_counter = '0;
        s_d.clr_cnt = s_q.clr_cnt - 3'h1;
        if (s_q.clr_cnt == 3'h1) begin
          s_d.fsm = acpc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{fsm: acpc_pkg::ST_RUN, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign retrigger          = s_q.retrigger;
  assign conv_done_flag     = s_q.conv_done_flag;
  assign threshold_irq_flag = s_q.threshold_irq_flag;
  assign acc_clear_busy     = (s_q.fsm == acpc_pkg::ST_CLEAR);

endmodule : acpc_core

`default_nettype wire

// File: rtl/acpc_pkg.sv
// Package: constants, register map and state types of the post-conversion compute unit
package acpc_pkg;

  // Data widths
  localparam int RES_W = 12;
  localparam int ACC_W = 18;
  localparam int CNT_W = 8;
  localparam int LIM_W = 16;
  localparam int ERR_W = 20;
  localparam int ADDR_W = 6;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_REPEAT = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ACC    = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_FILTER = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_UPPER  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_LOWER  = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_PREV   = 6'h24;

  // Control register field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_DOUBLE_SAMPLE_EN_BIT  = 3;
  localparam int CTRL_SHIFT_LSB = 4;
  localparam int CTRL_CLEAR_BIT = 8;
  localparam int CTRL_JUST_BIT  = 9;
  localparam int CTRL_THR_LSB   = 12;

  // Status register field positions
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_THR_BIT   = 1;
  localparam int ST_OVF_BIT   = 2;
  localparam int ST_UPPER_BIT = 3;
  localparam int ST_LOWER_BIT = 4;
  localparam int ST_BUSY_BIT  = 5;

  // Counter saturation value and clearing duration in converter clocks
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam logic [2:0] CLEAR_CYCLES = 3'h3;

  typedef enum logic [2:0] {
    MODE_BASIC = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_AVG   = 3'h2,
    MODE_BURST = 3'h3,
    MODE_LPF   = 3'h4
  } acpc_mode_t;

  typedef enum logic [2:0] {
    THR_NEVER   = 3'h0,
    THR_LT_LOW  = 3'h1,
    THR_GE_LOW  = 3'h2,
    THR_INSIDE  = 3'h3,
    THR_OUTSIDE = 3'h4,
    THR_LE_UP   = 3'h5,
    THR_GT_UP   = 3'h6,
    THR_ALWAYS  = 3'h7
  } acpc_thr_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h1,
    ST_CLEAR = 2'h2
  } acpc_fsm_t;

  // Software configuration
  typedef struct packed {
    logic [2:0]       compute_mode_sel;
    logic             double_sample_en;
    logic [2:0]       shift_count;
    logic             justify_left;
    logic [2:0]       thr_mode;
    logic [CNT_W-1:0] repeat_setting;
    logic [LIM_W-1:0] upper_limit;
    logic [LIM_W-1:0] lower_limit;
  } acpc_cfg_t;

  // Whole state of the unit
  typedef struct packed {
    acpc_fsm_t        fsm;
    logic [2:0]       clr_cnt;
    acpc_cfg_t        cfg;
    logic [ACC_W-1:0] accumulator;
    logic [CNT_W-1:0] sample_counter;
    logic [ACC_W-1:0] filter_output;
    logic [RES_W-1:0] current_result;
    logic [RES_W-1:0] previous_result;
    logic             second_phase;
    logic             conv_done_flag;
    logic             threshold_irq_flag;
    logic             acc_overflow_flag;
    logic             upper_flag;
    logic             lower_flag;
    logic             retrigger;
    logic [31:0]      rdata;
  } acpc_state_t;

endpackage : acpc_pkg

// File: testbench/acpc_conv_model.sv
// Conversion core model feeding results to the compute unit
`timescale 1ns/1ns
`default_nettype none
module acpc_conv_model (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Bench side
  input  wire logic                       go,
  input  wire logic                       slow,
  input  wire logic [acpc_pkg::RES_W-1:0] sample,
  // Unit side
  input  wire logic                       retrigger,
  output logic                            conv_trigger,
  output logic                            conv_valid,
  output logic      [acpc_pkg::RES_W-1:0] conv_result
);
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      conv_trigger <= 1'b0;
      conv_valid <= 1'b0;
      conv_result <= '0;
    end else begin
      conv_trigger <= go;
      conv_valid <= 1'b0;
      conv_result <= ~conv_result;
      if (go || retrigger) wait_q <= slow ? 4'h6 : 4'h1;
      else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        if (wait_q == 4'h1) begin
          conv_valid <= 1'b1;
          conv_result <= sample;
        end
      end
    end
  end
endmodule : acpc_conv_model
`default_nettype wire

// File: testbench/acpc_core_props.sv
// Port checker of the compute unit
`timescale 1ns/1ns
`default_nettype none
module acpc_core_props (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Register port
  input wire logic [acpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                 reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [31:0]                 reg_rdata,
  // Conversion core and status
  input wire logic                        conv_trigger,
  input wire logic                        conv_valid,
  input wire logic [acpc_pkg::RES_W-1:0]  conv_result,
  input wire logic                        retrigger,
  input wire logic                        conv_done_flag,
  input wire logic                        threshold_irq_flag,
  input wire logic                        acc_clear_busy
);
  logic [2:0] mode_q;
  logic       ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == acpc_pkg::OFS_CTRL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_q <= 3'h0;
    else if (ctl_wr) mode_q <= reg_wdata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_mode_rb;
    ctl_wr ##1 !ctl_wr ##1 (reg_rd && reg_addr == acpc_pkg::OFS_CTRL) |=>
      reg_rdata[2:0] == $past(reg_wdata[2:0], 3);
  endproperty
  property p_done; conv_valid |=> conv_done_flag; endproperty
  property p_done_hold; conv_done_flag && !reg_wr |=> conv_done_flag; endproperty
  property p_thr_cause; $rose(threshold_irq_flag) |-> $past(conv_valid); endproperty
  property p_clr_go; ctl_wr && reg_wdata[8] |=> acc_clear_busy; endproperty
  property p_clr_len; $rose(acc_clear_busy) |-> ##[1:5] !acc_clear_busy; endproperty
  property p_retrig_src; retrigger |-> $past(conv_valid); endproperty
  property p_retrig_mode; mode_q != 3'h3 && $past(mode_q) != 3'h3 |-> !retrigger; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_mode_rb: assert property (p_mode_rb) else $error("mode field readback");
  a_done: assert property (p_done) else $error("done flag missing");
  a_done_hold: assert property (p_done_hold) else $error("done flag lost");
  a_thr_cause: assert property (p_thr_cause) else $error("threshold without sample");
  a_clr_go: assert property (p_clr_go) else $error("clear not started");
  a_clr_len: assert property (p_clr_len) else $error("clear too long");
  a_retrig_src: assert property (p_retrig_src) else $error("retrigger without sample");
  a_retrig_mode: assert property (p_retrig_mode) else $error("retrigger off burst");
  c_retrig: cover property (retrigger);
  c_thr: cover property ($rose(threshold_irq_flag));
  c_clr: cover property ($fell(acc_clear_busy));
endmodule : acpc_core_props
bind acpc_core acpc_core_props props_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_trigger(conv_trigger), .conv_valid(conv_valid), .conv_result(conv_result),
  .retrigger(retrigger), .conv_done_flag(conv_done_flag),
  .threshold_irq_flag(threshold_irq_flag), .acc_clear_busy(acc_clear_busy));
`default_nettype wire

// File: testbench/acpc_core_tb.sv
// Self-checking bench of the compute unit
`timescale 1ns/1ns
`default_nettype none
module acpc_core_tb;
  logic                        clk, rst_n, reg_wr, reg_rd, go, slow;
  logic [acpc_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0]                 reg_wdata, reg_rdata, rv;
  logic [acpc_pkg::RES_W-1:0]  smp, res;
  logic                        trg, vld, rtg, done_f, thr_f, busy;
  int                          miscompares, cmp_count, cyc, acc, v, k, sh;
  acpc_core dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_trigger(trg),
    .conv_valid(vld), .conv_result(res), .retrigger(rtg), .conv_done_flag(done_f),
    .threshold_irq_flag(thr_f), .acc_clear_busy(busy));
  acpc_conv_model conv_u (.clk(clk), .rst_n(rst_n), .go(go), .slow(slow), .sample(smp),
    .retrigger(rtg), .conv_trigger(trg), .conv_valid(vld), .conv_result(res));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    chk(nm, e, rv);
  endtask : rc
  task automatic conv(input int s);
    @(posedge clk);
    smp <= 12'(s);
    go <= 1'b1;
    slow <= 1'($urandom_range(1, 0));
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (vld !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (2) @(posedge clk);
  endtask : conv
  function automatic logic thr_hit(input int m, input int e);
    case (m)
      1: return e < -16;
      2: return e >= -16;
      3: return e >= -16 && e <= 200;
      4: return e < -16 || e > 200;
      5: return e <= 200;
      6: return e > 200;
      7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : thr_hit
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, go, slow} = 5'h0;
    {reg_addr, reg_wdata, smp} = '0;
    v = $urandom(74);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc("ctrl reset", acpc_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) conv($urandom_range(4095, 0));
    rc("basic acc", acpc_pkg::OFS_ACC, 32'h0);
    rc("basic count", acpc_pkg::OFS_COUNT, 32'h0);
    chk("done", 32'h1, 32'(done_f));
    wr(acpc_pkg::OFS_UPPER, 32'h00c8);
    wr(acpc_pkg::OFS_LOWER, 32'hfff0);
    for (int i = 0; i < 16; i++) begin
      wr(acpc_pkg::OFS_CTRL, 32'(i / 2) << 12);
      wr(acpc_pkg::OFS_STATUS, 32'h3f);
      v = $urandom_range(400, 0);
      conv(v);
      chk("thr basic", 32'(thr_hit(i / 2, v)), 32'(thr_f));
    end
    $display("test basic end");
    sh = $urandom_range(7, 0);
    wr(acpc_pkg::OFS_CTRL, 32'h7201 | (32'(sh) << 4));
    acc = 0;
    for (int i = 0; i < 260; i++) begin
      v = 32'h800 | $urandom_range(2047, 0);
      if (i == 3) wr(acpc_pkg::OFS_STATUS, 32'h2);
      conv(v);
      acc += v;
      if (i == 3) chk("thr acc", 32'h1, 32'(thr_f));
      if (i == 3) rc("acc", acpc_pkg::OFS_ACC, 32'(acc));
    end
    rc("filter", acpc_pkg::OFS_FILTER, (32'(acc) & 32'h3ffff) >> sh);
    rc("acc wrap", acpc_pkg::OFS_ACC, 32'(acc) & 32'h3ffff);
    rc("count sat", acpc_pkg::OFS_COUNT, 32'hff);
    chk("thr ovf", 32'h1, 32'(thr_f));
    // Done, threshold and overflow set; upper flag follows the last filter value
    v = 7 | ((((acc & 32'h3ffff) >> sh) > 200) ? 8 : 0);
    rc("status", acpc_pkg::OFS_STATUS, 32'(v));
    chk("ovf", 32'h1, 32'(rv[2]));
    $display("test accumulate end");
    wr(acpc_pkg::OFS_STATUS, 32'h3f);
    wr(acpc_pkg::OFS_CTRL, 32'h0101);
    k = 0;
    #1;
    chk("clear busy", 32'h1, 32'(busy));
    while (busy !== 1'b0 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("clear time", 32'h1, 32'(k <= 5));
    rc("acc clr", acpc_pkg::OFS_ACC, 32'h0);
    rc("count clr", acpc_pkg::OFS_COUNT, 32'h0);
    rc("status clr", acpc_pkg::OFS_STATUS, 32'h0);
    chk("ovf clr", 32'h0, 32'(rv[2]));
    rc("ctrl clr", acpc_pkg::OFS_CTRL, 32'h0001);
    wr(acpc_pkg::OFS_CTRL, 32'h0009);
    rc("ctrl ds", acpc_pkg::OFS_CTRL, 32'h0009);
    v = $urandom_range(1000, 500);
    conv(v);
    rc("ds count", acpc_pkg::OFS_COUNT, 32'h0);
    conv(v + 300);
    conv(v);
    conv(v - 100);
    rc("ds count", acpc_pkg::OFS_COUNT, 32'h2);
    rc("ds acc", acpc_pkg::OFS_ACC, 32'd200);
    $display("test double end");
    wr(acpc_pkg::OFS_CTRL, 32'h7102);
    wr(acpc_pkg::OFS_REPEAT, 32'h3);
    wr(acpc_pkg::OFS_STATUS, 32'h3f);
    for (int i = 0; i < 3; i++) begin
      conv($urandom_range(4095, 0));
      chk("thr avg", 32'(i == 2), 32'(thr_f));
    end
    v = $urandom_range(4095, 0);
    conv(v);
    rc("avg acc", acpc_pkg::OFS_ACC, 32'(v));
    rc("avg count", acpc_pkg::OFS_COUNT, 32'h1);
    $display("test average end");
    wr(acpc_pkg::OFS_CTRL, 32'h7103);
    wr(acpc_pkg::OFS_REPEAT, 32'h4);
    wr(acpc_pkg::OFS_STATUS, 32'h3f);
    v = $urandom_range(4095, 0);
    conv(v);
    repeat (60) @(posedge clk);
    rc("burst count", acpc_pkg::OFS_COUNT, 32'h4);
    rc("burst acc", acpc_pkg::OFS_ACC, 32'(4 * v));
    chk("thr burst", 32'h1, 32'(thr_f));
    $display("test burst end");
    wr(acpc_pkg::OFS_CTRL, 32'h7124);
    wr(acpc_pkg::OFS_REPEAT, 32'h2);
    wr(acpc_pkg::OFS_STATUS, 32'h3f);
    acc = 0;
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(4095, 0);
      conv(v);
      acc = (v + acc - (acc >> 2)) & 32'h3ffff;
      rc("lpf acc", acpc_pkg::OFS_ACC, 32'(acc));
      chk("thr lpf", 32'(i > 0), 32'(thr_f));
    end
    $display("test lowpass end");
    wrap_up();
  end
endmodule : acpc_core_tb
`default_nettype wire
